// [hdl/cdpf_cfg_if.sv]
// Purpose: record filter settings shared by both channel filters
// Assumes: driven from the register block
// Notes: one source, any number of readers
`timescale 1ns/1ps
interface cdpf_cfg_if;
  logic hp_en;
  logic hp_2nd;
  logic signed [16:0] alpha;
  logic notch_en;
  logic signed [13:0] a0;
  logic signed [13:0] a1;
  modport src (output hp_en, hp_2nd, alpha, notch_en, a0, a1);
  modport dst (input hp_en, hp_2nd, alpha, notch_en, a0, a1);
endinterface

// [hdl/cdpf_defs.svh]
// Purpose: constants for the codec digital path filter and mute block
// Assumes: word-indexed Avalon-MM slave, 9-bit registers in the low bits
// Notes: fields are given as msb:lsb so they can be used as part-selects
`ifndef CDPF_DEFS_SVH
`define CDPF_DEFS_SVH
// register indices (byte address is four times the index)
`define CDPF_IDX_PASS 6'h05
`define CDPF_IDX_RATE 6'h07
`define CDPF_IDX_DCTL 6'h0A
`define CDPF_IDX_FILT 6'h0E
`define CDPF_IDX_A0H 6'h1B
`define CDPF_IDX_A0L 6'h1C
`define CDPF_IDX_A1H 6'h1D
`define CDPF_IDX_A1L 6'h1E
`define CDPF_IDX_STAT 6'h3F
// fields
`define CDPF_B_UPD 8
`define CDPF_B_NEN 7
`define CDPF_B_HPEN 8
`define CDPF_B_HPAM 7
`define CDPF_F_HPC 6:4
`define CDPF_F_COEF 6:0
`define CDPF_F_RATE 3:1
`define CDPF_B_PASS 0
`define CDPF_B_SMUTE 6
`define CDPF_B_AMUTE 5
`define CDPF_B_OSR 3
`define CDPF_B_POLR 1
`define CDPF_B_POLL 0
// reset values
`define CDPF_RST_FILT 9'h100
`define CDPF_RST_DCTL 9'h000
// high-pass smoothing factors, Q16, at the 32/44.1/48 kHz group
`define CDPF_ALPHA_AUDIO 17'sh00020
`define CDPF_ALPHA_C0 17'sh00417
`define CDPF_ALPHA_C1 17'sh00521
`define CDPF_ALPHA_C2 17'sh0053B
`define CDPF_ALPHA_C3 17'sh00836
`define CDPF_ALPHA_C4 17'sh00A42
`define CDPF_ALPHA_C5 17'sh00D24
`define CDPF_ALPHA_C6 17'sh0106C
`define CDPF_ALPHA_C7 17'sh01483
`define CDPF_HP_SHIFT 16
`define CDPF_NOTCH_ONE 48'sh2000
`define CDPF_NOTCH_SHIFT 13
// playback
`define CDPF_GAIN_FULL 9'h100
`define CDPF_GAIN_SHIFT 8
`define CDPF_AMUTE_RUN 11'h400
`endif

// [hdl/cdpf_pkg.sv]
// Purpose: shared types and saturation helper
// Assumes: nothing
// Notes: used without import
package cdpf_pkg;
  typedef enum logic [1:0] {
    cdpf_st_idle = 2'b01,
    cdpf_st_ack = 2'b10
  } cdpf_bus_st_t;

  typedef logic signed [23:0] cdpf_smp_t;

  function automatic cdpf_smp_t cdpf_sat24(input logic signed [47:0] v);
    if (v > 48'sh7FFFFF) begin
      return 24'sh7FFFFF;
    end else if (v < -48'sh800000) begin
      return 24'sh800000;
    end
    return v[23:0];
  endfunction
endpackage

// [hdl/cdpf_rec_chan.sv]
// Purpose: one record channel, high-pass then notch
// Assumes: fs_stb_in is a one-cycle pulse per sample
// Notes: output is registered on the strobe edge
`timescale 1ns/1ps
module cdpf_rec_chan (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // shared settings
  cdpf_cfg_if.dst cfg,
  // samples
  input wire logic fs_stb_in,
  input wire logic signed [23:0] x_in,
  output logic signed [23:0] y_out
);
  `include "cdpf_defs.svh"
  logic signed [25:0] lp1_r, lp1_nxt, lp2_r, lp2_nxt, d1, d2, hp_w;
  logic signed [23:0] nx, ny, yv, x1_r, x2_r, y1_r, y2_r;
  logic signed [47:0] c0, c1, acc;

  // one-pole low-pass tracks, high-pass is the difference
  assign d1 = 26'(x_in) - lp1_r;
  assign lp1_nxt = lp1_r + 26'((44'(d1) * 44'(cfg.alpha)) >>> `CDPF_HP_SHIFT);
  // second pole cascaded for application mode
  assign d2 = d1 - lp2_r;
  assign lp2_nxt = lp2_r + 26'((44'(d2) * 44'(cfg.alpha)) >>> `CDPF_HP_SHIFT);
  assign hp_w = !cfg.hp_en ? 26'(x_in) : (cfg.hp_2nd ? d2 : d1);

  // notch sits after the high-pass
  assign nx = cdpf_pkg::cdpf_sat24(48'(hp_w));
  assign c0 = 48'(cfg.a0);
  assign c1 = 48'(cfg.a1);
  // y*8192 = ((8192-c0)(x+x2))/2 - 2c1*x1 + 2c1*y1 + c0*y2
  assign acc = (((`CDPF_NOTCH_ONE - c0) * (48'(nx) + 48'(x2_r))) >>> 1)
             - ((c1 * 48'(x1_r)) <<< 1)
             + ((c1 * 48'(y1_r)) <<< 1)
             + (c0 * 48'(y2_r));
  assign ny = cdpf_pkg::cdpf_sat24(acc >>> `CDPF_NOTCH_SHIFT);
  assign yv = cfg.notch_en ? ny : nx;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lp1_r <= '0;
      lp2_r <= '0;
      x1_r <= '0;
      x2_r <= '0;
      y1_r <= '0;
      y2_r <= '0;
      y_out <= '0;
    end else if (fs_stb_in) begin
      lp1_r <= lp1_nxt;
      lp2_r <= lp2_nxt;
      x1_r <= nx;
      x2_r <= x1_r;
      y1_r <= ny;
      y2_r <= y1_r;
      y_out <= yv;
    end
  end
endmodule // cdpf_rec_chan

// [hdl/cdpf_top.sv]
// Purpose: record high-pass and notch, playback mute, polarity, passthrough
// Assumes: samples are synchronous to clk_sys_in, one strobe per sample
// Notes: one wait state on every bus access
`timescale 1ns/1ps
module cdpf_top (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // register bus
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // record converter samples
  input wire logic fs_stb_in,
  input wire logic signed [23:0] adc_l_in,
  input wire logic signed [23:0] adc_r_in,
  output logic signed [23:0] rec_l_out,
  output logic signed [23:0] rec_r_out,
  output logic rec_valid_out,
  // playback samples
  input wire logic signed [15:0] dai_l_in,
  input wire logic signed [15:0] dai_r_in,
  output logic signed [23:0] dac_l_out,
  output logic signed [23:0] dac_r_out,
  output logic dac_valid_out,
  output logic dac_muted_out,
  output logic dac_osr128_out
);
  `include "cdpf_defs.svh"

  // bus slave state
  cdpf_pkg::cdpf_bus_st_t st_r, st_nxt;
  logic wait_nxt;
  logic [31:0] rdata_nxt;
  logic wr_go, rd_take;
  logic [8:0] wdata;
  logic [8:0] rd_mux;
  logic [8:0] status_w;

  // registers
  logic [8:0] filt_r, filt_nxt;
  logic [8:0] dctl_r, dctl_nxt;
  logic pass_r, pass_nxt;
  logic [2:0] rate_r, rate_nxt;
  logic notch_en_r, notch_en_nxt;
  logic [6:0] pend_r [4];
  logic [6:0] pend_nxt [4];
  logic [6:0] act_r [4];
  logic [6:0] act_nxt [4];
  logic [2:0] coef_dec;
  logic [27:0] act_flat, pend_flat;

  // record path
  cdpf_cfg_if cfg ();
  logic signed [23:0] adc_w [2];
  logic signed [23:0] rec_w [2];
  logic signed [16:0] hp_base, alpha_w;
  logic [1:0] rate_shift;
  logic rec_valid_r;

  // playback path
  logic signed [23:0] src_l, src_r;
  logic zero_w;
  logic [10:0] zcnt_r, zcnt_nxt;
  logic mute_nxt;
  logic [8:0] gain_r, gain_nxt;
  logic signed [23:0] dac_l_nxt, dac_r_nxt;
  logic dac_valid_r;

  // coefficient register decode: {hit, slot}
  function automatic logic [2:0] coef_slot(input logic [5:0] idx);
    case (idx)
      `CDPF_IDX_A0H: coef_slot = 3'h4;
      `CDPF_IDX_A0L: coef_slot = 3'h5;
      `CDPF_IDX_A1H: coef_slot = 3'h6;
      `CDPF_IDX_A1L: coef_slot = 3'h7;
      default: coef_slot = 3'h0;
    endcase
  endfunction

  // application mode smoothing factor per corner code
  function automatic logic signed [16:0] alpha_tab(input logic [2:0] code);
    case (code)
      3'h0: alpha_tab = `CDPF_ALPHA_C0;
      3'h1: alpha_tab = `CDPF_ALPHA_C1;
      3'h2: alpha_tab = `CDPF_ALPHA_C2;
      3'h3: alpha_tab = `CDPF_ALPHA_C3;
      3'h4: alpha_tab = `CDPF_ALPHA_C4;
      3'h5: alpha_tab = `CDPF_ALPHA_C5;
      3'h6: alpha_tab = `CDPF_ALPHA_C6;
      3'h7: alpha_tab = `CDPF_ALPHA_C7;
      default: alpha_tab = `CDPF_ALPHA_C0;
    endcase
  endfunction

  // gain, polarity and saturation for one playback channel
  function automatic logic signed [23:0] play_chan(
    input logic signed [23:0] s,
    input logic [8:0] g,
    input logic pol
  );
    logic signed [47:0] p;
    p = (48'(s) * 48'(signed'({1'b0, g}))) >>> `CDPF_GAIN_SHIFT;
    if (pol) begin
      p = -p;
    end
    return cdpf_pkg::cdpf_sat24(p);
  endfunction

  // ---- bus slave: request taken in idle, answered in ack
  assign wdata = avs_writedata_in[8:0];
  assign rd_take = avs_read_in && (st_r == cdpf_pkg::cdpf_st_idle);
  assign wr_go = avs_write_in && (st_r == cdpf_pkg::cdpf_st_ack);
  assign st_nxt = ((st_r == cdpf_pkg::cdpf_st_idle) &&
                   (avs_read_in || avs_write_in)) ?
                  cdpf_pkg::cdpf_st_ack : cdpf_pkg::cdpf_st_idle;
  assign wait_nxt = (st_nxt != cdpf_pkg::cdpf_st_ack);
  assign coef_dec = coef_slot(avs_address_in);

  assign status_w = {6'h00, (gain_r == `CDPF_GAIN_FULL), (gain_r == 9'h000),
                     dac_muted_out};
  // update bit always reads zero
  assign rd_mux =
    (avs_address_in == `CDPF_IDX_FILT) ? filt_r :
    (avs_address_in == `CDPF_IDX_DCTL) ? dctl_r :
    (avs_address_in == `CDPF_IDX_PASS) ? {8'h00, pass_r} :
    (avs_address_in == `CDPF_IDX_RATE) ? {5'h00, rate_r, 1'b0} :
    (avs_address_in == `CDPF_IDX_STAT) ? status_w :
    coef_dec[2] ? {1'b0, (coef_dec[1:0] == 2'h0) && notch_en_r,
                   pend_r[coef_dec[1:0]]} :
    9'h000;
  assign rdata_nxt = rd_take ? {23'h000000, rd_mux} : avs_readdata_out;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= cdpf_pkg::cdpf_st_idle;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      avs_waitrequest_out <= wait_nxt;
      avs_readdata_out <= rdata_nxt;
    end
  end

  // ---- control registers
  assign filt_nxt = (wr_go && avs_address_in == `CDPF_IDX_FILT) ?
                    wdata : filt_r;
  assign dctl_nxt = (wr_go && avs_address_in == `CDPF_IDX_DCTL) ?
                    wdata : dctl_r;
  assign pass_nxt = (wr_go && avs_address_in == `CDPF_IDX_PASS) ?
                    wdata[`CDPF_B_PASS] : pass_r;
  assign rate_nxt = (wr_go && avs_address_in == `CDPF_IDX_RATE) ?
                    wdata[`CDPF_F_RATE] : rate_r;
  assign notch_en_nxt = (wr_go && avs_address_in == `CDPF_IDX_A0H) ?
                        wdata[`CDPF_B_NEN] : notch_en_r;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      filt_r <= `CDPF_RST_FILT;
      dctl_r <= `CDPF_RST_DCTL;
      pass_r <= 1'b0;
      rate_r <= 3'h0;
      notch_en_r <= 1'b0;
    end else begin
      filt_r <= filt_nxt;
      dctl_r <= dctl_nxt;
      pass_r <= pass_nxt;
      rate_r <= rate_nxt;
      notch_en_r <= notch_en_nxt;
    end
  end

  // ---- notch coefficients: pending copy and live copy per register
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_coef
      assign pend_nxt[k] = (wr_go && coef_dec[2] && coef_dec[1:0] == 2'(k)) ?
                           wdata[`CDPF_F_COEF] : pend_r[k];
      assign act_nxt[k] = (wr_go && coef_dec[2] && wdata[`CDPF_B_UPD]) ?
                          pend_nxt[k] : act_r[k];
      assign act_flat[k*7 +: 7] = act_r[k];
      assign pend_flat[k*7 +: 7] = pend_r[k];
      always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
          pend_r[k] <= 7'h00;
          act_r[k] <= 7'h00;
        end else begin
          pend_r[k] <= pend_nxt[k];
          act_r[k] <= act_nxt[k];
        end
      end
    end
  endgenerate

  // ---- record path settings
  assign rate_shift = (rate_r[2:1] == 2'h2) ? 2'h2 :
                      (rate_r[2:1] == 2'h1) ? 2'h1 : 2'h0;
  assign hp_base = filt_r[`CDPF_B_HPAM] ? alpha_tab(filt_r[`CDPF_F_HPC]) :
                   `CDPF_ALPHA_AUDIO;
  assign alpha_w = 17'(hp_base <<< rate_shift);
  assign cfg.hp_en = filt_r[`CDPF_B_HPEN];
  assign cfg.hp_2nd = filt_r[`CDPF_B_HPAM];
  assign cfg.alpha = alpha_w;
  assign cfg.notch_en = notch_en_r;
  assign cfg.a0 = {act_r[0], act_r[1]};
  assign cfg.a1 = {act_r[2], act_r[3]};

  assign adc_w[0] = adc_l_in;
  assign adc_w[1] = adc_r_in;
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_rec
      cdpf_rec_chan u_chan (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .cfg(cfg.dst),
        .fs_stb_in(fs_stb_in),
        .x_in(adc_w[c]),
        .y_out(rec_w[c])
      );
    end
  endgenerate
  assign rec_l_out = rec_w[0];
  assign rec_r_out = rec_w[1];

  // ---- playback path
  assign src_l = pass_r ? rec_l_out : {dai_l_in, 8'h00};
  assign src_r = pass_r ? rec_r_out : {dai_r_in, 8'h00};
  assign zero_w = (src_l == 24'sh000000) && (src_r == 24'sh000000);
  assign zcnt_nxt = !fs_stb_in ? zcnt_r :
                    !zero_w ? 11'h000 :
                    (zcnt_r == `CDPF_AMUTE_RUN) ? zcnt_r :
                    zcnt_r + 11'h001;
  assign mute_nxt = dctl_r[`CDPF_B_AMUTE] &&
                    (zcnt_nxt == `CDPF_AMUTE_RUN);
  // one gain step per sample, ramp runs over 256 samples
  assign gain_nxt = !fs_stb_in ? gain_r :
                    dctl_r[`CDPF_B_SMUTE] ?
                    ((gain_r == 9'h000) ? gain_r : gain_r - 9'h001) :
                    ((gain_r == `CDPF_GAIN_FULL) ? gain_r :
                     gain_r + 9'h001);
  assign dac_l_nxt = !fs_stb_in ? dac_l_out :
                     mute_nxt ? 24'sh000000 :
                     play_chan(src_l, gain_r, dctl_r[`CDPF_B_POLL]);
  assign dac_r_nxt = !fs_stb_in ? dac_r_out :
                     mute_nxt ? 24'sh000000 :
                     play_chan(src_r, gain_r, dctl_r[`CDPF_B_POLR]);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      zcnt_r <= 11'h000;
      gain_r <= `CDPF_GAIN_FULL;
      dac_l_out <= 24'sh000000;
      dac_r_out <= 24'sh000000;
      dac_muted_out <= 1'b0;
      dac_valid_r <= 1'b0;
      rec_valid_r <= 1'b0;
      dac_osr128_out <= 1'b0;
    end else begin
      zcnt_r <= zcnt_nxt;
      gain_r <= gain_nxt;
      dac_l_out <= dac_l_nxt;
      dac_r_out <= dac_r_nxt;
      dac_muted_out <= mute_nxt;
      dac_valid_r <= fs_stb_in;
      rec_valid_r <= fs_stb_in;
      dac_osr128_out <= dctl_r[`CDPF_B_OSR];
    end
  end
  assign dac_valid_out = dac_valid_r;
  assign rec_valid_out = rec_valid_r;

  // ---- checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  a_filter_bypass: assert property (
    (fs_stb_in && !filt_r[`CDPF_B_HPEN] && !notch_en_r)
    |=> (rec_l_out == $past(adc_l_in)) && (rec_r_out == $past(adc_r_in)))
    else $error("record sample altered while filters are off");

  a_pending_holds: assert property (
    (wr_go && coef_dec[2] && !wdata[`CDPF_B_UPD]) |=> $stable(act_flat))
    else $error("live coefficients changed without update bit");

  a_update_all: assert property (
    (wr_go && coef_dec[2] && wdata[`CDPF_B_UPD]) |=> (act_flat == pend_flat))
    else $error("update did not move every pending coefficient");

  a_update_reads_zero: assert property (
    (rd_take && coef_dec[2]) |=> !avs_readdata_out[`CDPF_B_UPD])
    else $error("update bit read back as one");

  a_softmute_ramp: assert property (
    (fs_stb_in && dctl_r[`CDPF_B_SMUTE] && gain_r != 9'h000)
    |=> (gain_r == $past(gain_r) - 9'h001))
    else $error("soft mute gain did not step down");

  a_automute_clear: assert property (
    (fs_stb_in && !zero_w) |=> (zcnt_r == 11'h000) && !dac_muted_out)
    else $error("non-zero sample did not clear automute");

  a_automute_trip: assert property (
    (fs_stb_in && dctl_r[`CDPF_B_AMUTE] && zero_w &&
     zcnt_r == `CDPF_AMUTE_RUN - 11'h001)
    |=> dac_muted_out && (dac_l_out == 24'sh000000) &&
        (dac_r_out == 24'sh000000))
    else $error("automute missed the 1024th zero sample");

  a_mute_holds: assert property (
    (!fs_stb_in && $stable(dctl_r)) |=> $stable(dac_muted_out))
    else $error("mute state changed between samples");

  a_automute_off: assert property (
    !dctl_r[`CDPF_B_AMUTE] |=> !dac_muted_out)
    else $error("outputs muted while automute is off");

  a_polarity_sign: assert property (
    (fs_stb_in && gain_r == `CDPF_GAIN_FULL && !mute_nxt &&
     src_l != 24'sh800000)
    |=> dac_l_out == ($past(dctl_r[`CDPF_B_POLL]) ? -$past(src_l) :
                      $past(src_l)))
    else $error("left polarity result wrong");

  a_polarity_right: assert property (
    (fs_stb_in && gain_r == `CDPF_GAIN_FULL && !mute_nxt &&
     src_r != 24'sh800000)
    |=> dac_r_out == ($past(dctl_r[`CDPF_B_POLR]) ? -$past(src_r) :
                      $past(src_r)))
    else $error("right polarity result wrong");

  a_passthru_src: assert property (
    (fs_stb_in && pass_r && gain_r == `CDPF_GAIN_FULL && !mute_nxt &&
     !dctl_r[`CDPF_B_POLR]) |=> (dac_r_out == $past(rec_r_out)))
    else $error("passthrough did not use record sample");

  a_play_widen: assert property (
    (fs_stb_in && !pass_r && gain_r == `CDPF_GAIN_FULL && !mute_nxt &&
     !dctl_r[`CDPF_B_POLL])
    |=> (dac_l_out[7:0] == 8'h00) && (dac_l_out[23:8] == $past(dai_l_in)))
    else $error("16-bit sample not widened to 24 bits");

  c_coef_update: cover property (wr_go && coef_dec[2] && wdata[`CDPF_B_UPD]);
  c_automute: cover property ($rose(dac_muted_out));
  c_softmute_done: cover property (dctl_r[`CDPF_B_SMUTE] && gain_r == 9'h000);
  c_passthru: cover property (fs_stb_in && pass_r && src_l != 24'sh000000);
endmodule // cdpf_top

// [verification/cdpf_src.sv]
// Purpose: sample source standing in for the audio data port
// Assumes: the bench sets the values to send between strobes
// Notes: data toggles outside the strobe cycle so stale data shows
`timescale 1ns/1ps
module cdpf_src #(
  parameter int GAP = 4
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // values to send
  input wire logic signed [23:0] adc_in,
  input wire logic signed [15:0] dai_in,
  // sample port
  output logic fs_stb_out,
  output logic signed [23:0] adc_out,
  output logic signed [15:0] dai_out
);
  logic [7:0] cnt_r;
  logic last;
  assign last = (cnt_r == 8'(GAP - 1));
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= 8'h00;
      fs_stb_out <= 1'b0;
      adc_out <= 24'sh000000;
      dai_out <= 16'sh0000;
    end else begin
      cnt_r <= last ? 8'h00 : cnt_r + 8'h01;
      fs_stb_out <= last;
      adc_out <= last ? adc_in : ~adc_out;
      dai_out <= last ? dai_in : ~dai_out;
    end
  end
endmodule // cdpf_src

// [verification/testbench.sv]
// Purpose: self-checking bench for record filters and playback path
// Assumes: one wait state per bus access, a strobe every four clocks
// Notes: expected values follow the filter equations and bit map
`timescale 1ns/1ps
`include "cdpf_defs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  failures++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic wreq;
  logic fs_stb;
  logic signed [23:0] adc_v = 24'sh000000;
  logic signed [15:0] dai_v = 16'sh0000;
  logic signed [23:0] adc_s, rec_l, rec_r, dac_l, dac_r;
  logic signed [15:0] dai_s;
  logic rec_vld, dac_vld, muted, osr;
  int failures = 0;
  int num_checks = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  cdpf_src u_cdpf_src (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .adc_in(adc_v), .dai_in(dai_v), .fs_stb_out(fs_stb),
    .adc_out(adc_s), .dai_out(dai_s));
  cdpf_top u_cdpf_top (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .avs_address_in(adr), .avs_read_in(rd_en), .avs_write_in(wr_en),
    .avs_writedata_in(wdat), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .fs_stb_in(fs_stb), .adc_l_in(adc_s),
    .adc_r_in(adc_s), .rec_l_out(rec_l), .rec_r_out(rec_r),
    .rec_valid_out(rec_vld), .dai_l_in(dai_s), .dai_r_in(dai_s),
    .dac_l_out(dac_l), .dac_r_out(dac_r), .dac_valid_out(dac_vld),
    .dac_muted_out(muted), .dac_osr128_out(osr));
  task automatic conclude();
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [8:0] d);
    @(posedge clk_sys_in);
    adr <= a;
    wdat <= {23'h000000, d};
    wr_en <= 1'b1;
    do @(posedge clk_sys_in); while (wreq !== 1'b0);
    wr_en <= 1'b0;
  endtask
  task automatic chk_rd(input string n, input logic [5:0] a,
                        input logic [8:0] e);
    logic [31:0] d;
    @(posedge clk_sys_in);
    adr <= a;
    rd_en <= 1'b1;
    do @(posedge clk_sys_in); while (wreq !== 1'b0);
    d = rdat;
    rd_en <= 1'b0;
    `CHK(n, {23'h000000, e}, d)
  endtask
  // wait for n record results
  task automatic smp(input int n);
    repeat (n) begin
      do @(posedge clk_sys_in); while (rec_vld !== 1'b1);
    end
  endtask
  // one sample in, its result out; caller is aligned to a result
  task automatic feed(input logic signed [23:0] a,
                      input logic signed [15:0] d);
    @(posedge clk_sys_in);
    adc_v <= a;
    dai_v <= d;
    smp(1);
  endtask
  task automatic t_regs();
    chk_rd("filt_rst", `CDPF_IDX_FILT, 9'h100);
    chk_rd("dctl_rst", `CDPF_IDX_DCTL, 9'h000);
    wr(6'h00, 9'h1FF);
    chk_rd("unmapped", 6'h00, 9'h000);
  endtask
  task automatic t_hp();
    smp(1);
    repeat (40) feed(24'sh100000, 16'sh0000);
    `CHK("hp_lr", rec_l, rec_r)
    `CHK("hp_audio", 1'b1, rec_l > 24'sh080000 && rec_l < 24'sh100000)
    wr(`CDPF_IDX_FILT, 9'h1F0);
    smp(1);
    repeat (40) feed(24'sh100000, 16'sh0000);
    `CHK("hp_app", 1'b1, rec_l < 24'sh040000 && rec_l > -24'sh040000)
    // low rate group: corner factor four times larger, output falls below half the step after two steps
    wr(`CDPF_IDX_RATE, 9'h00A);
    chk_rd("rate_rb", `CDPF_IDX_RATE, 9'h00A);
    smp(1);
    repeat (40) feed(24'sh000000, 16'sh0000);
    repeat (2) feed(24'sh100000, 16'sh0000);
    `CHK("hp_rate", 1'b1, rec_l > 24'sh040000 && rec_l < 24'sh080000)
  endtask
  task automatic t_notch();
    wr(`CDPF_IDX_FILT, 9'h000);
    smp(1);
    feed(24'sh012345, 16'sh0000);
    `CHK("bypass", 24'sh012345, rec_l)
    // a0 = 4096 with notch on, held pending
    wr(`CDPF_IDX_A0H, 9'h0A0);
    chk_rd("a0h_pend", `CDPF_IDX_A0H, 9'h0A0);
    smp(1);
    repeat (3) feed(24'sh000000, 16'sh0000);
    feed(24'sh002000, 16'sh0000);
    `CHK("notch_old", 24'sh001000, rec_l)
    repeat (4) feed(24'sh000000, 16'sh0000);
    wr(`CDPF_IDX_A1L, 9'h100);
    chk_rd("upd_wo", `CDPF_IDX_A1L, 9'h000);
    smp(1);
    feed(24'sh002000, 16'sh0000);
    `CHK("notch_new", 24'sh000800, rec_l)
    `CHK("notch_lr", rec_l, rec_r)
  endtask
  task automatic t_play();
    wr(`CDPF_IDX_DCTL, 9'h009);
    smp(1);
    feed(24'sh000000, 16'sh03E8);
    `CHK("pol_l", 24'shFC1800, dac_l)
    `CHK("pol_r", 24'sh03E800, dac_r)
    `CHK("osr", 1'b1, osr)
    `CHK("dac_vld", 1'b1, dac_vld)
    wr(`CDPF_IDX_DCTL, 9'h002);
    smp(1);
    feed(24'sh000000, 16'sh03E8);
    `CHK("polr_l", 24'sh03E800, dac_l)
    `CHK("polr_r", 24'shFC1800, dac_r)
    `CHK("osr_off", 1'b0, osr)
  endtask
  task automatic t_mute();
    wr(`CDPF_IDX_DCTL, 9'h020);
    smp(1);
    feed(24'sh000000, 16'sh0001);
    repeat (1023) feed(24'sh000000, 16'sh0000);
    `CHK("amute_1023", 1'b0, muted)
    feed(24'sh000000, 16'sh0000);
    `CHK("amute_1024", 1'b1, muted)
    `CHK("amute_out", 24'sh000000, dac_l)
    chk_rd("stat_mute", `CDPF_IDX_STAT, 9'h005);
    smp(1);
    feed(24'sh000000, 16'sh03E8);
    `CHK("amute_clr", 1'b0, muted)
    wr(`CDPF_IDX_DCTL, 9'h040);
    smp(10);
    `CHK("ramp", 1'b1, dac_l > 24'sh000000 && dac_l < 24'sh03E800)
    smp(260);
    `CHK("smute_0", 24'sh000000, dac_r)
    chk_rd("stat_0", `CDPF_IDX_STAT, 9'h002);
    wr(`CDPF_IDX_DCTL, 9'h000);
    smp(260);
    `CHK("smute_up", 24'sh03E800, dac_l)
    chk_rd("stat_full", `CDPF_IDX_STAT, 9'h004);
  endtask
  task automatic t_pass();
    wr(`CDPF_IDX_A0H, 9'h020);
    wr(`CDPF_IDX_PASS, 9'h001);
    smp(1);
    feed(24'sh012300, 16'sh7FFF);
    feed(24'sh012300, 16'sh7FFF);
    `CHK("pass_l", 24'sh012300, dac_l)
    `CHK("pass_rec", 24'sh012300, rec_l)
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    t_regs();
    t_hp();
    t_notch();
    t_play();
    t_mute();
    t_pass();
    conclude();
  end
  // about 7000 cycles are needed; cut a hang well beyond that
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    failures++;
    conclude();
  end
endmodule // testbench
